// file: common/tic_consts.vh
// constants for the terminal input conditioning block
`ifndef TIC_CONSTS_VH
`define TIC_CONSTS_VH
// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define TIC_CLK_PERIOD_NS   50
`define TIC_MS_TIME_NS      1000000
`define TIC_TICK10_MS       10
`define TIC_TICK100_PER10   10
`define TIC_GATE_TICKS10    10
`define TIC_HZ_PER_COUNT    10
// --------------------------------------------------------------------
// terminal command modes
// --------------------------------------------------------------------
`define TIC_MODE_TWO_1      2'h0
`define TIC_MODE_TWO_2      2'h1
`define TIC_MODE_THREE_1    2'h2
`define TIC_MODE_THREE_2    2'h3
// --------------------------------------------------------------------
// reset values and scaling
// --------------------------------------------------------------------
`define TIC_DIN_FILT_DEF    10'h00A
`define TIC_PULSE_FILT_DEF  10'h001
`define TIC_AI_FILT_DEF     10'h00A
`define TIC_UPDOWN_RATE_DEF 16'h03E8
`define TIC_UHZ_PER_CHZ     17'h02710
`define TIC_PULSE_MAX_HZ    16'hC350
`define TIC_AI_MAX_MV       14'h3FFF
`define TIC_CURVE_SEL_2     3'h2
`define TIC_CURVE_SEL_3     3'h3
`endif

// file: rtl/tic_curve.v
// two-point linear curve with clamping and first-order smoothing
`timescale 1ns/1ns
module tic_curve #(
    parameter XW = 14
) (
    input  wire                 mclk_i,
    input  wire                 rst_i,
    input  wire                 tick_i,
    input  wire [XW-1:0]        x_i,
    input  wire [XW-1:0]        xmin_i,
    input  wire [XW-1:0]        xmax_i,
    input  wire signed [10:0]   ymin_i,
    input  wire signed [10:0]   ymax_i,
    input  wire                 below_zero_i,
    input  wire [9:0]           filt_i,
    output reg  signed [10:0]   y_o
);
    // ----------------------------------------------------------------
    // straight line between the two points
    // ----------------------------------------------------------------
    wire [XW-1:0]          xc    = (x_i > xmax_i) ? xmax_i : x_i;
    wire signed [11:0]     dy    = {ymax_i[10], ymax_i} - {ymin_i[10], ymin_i};
    wire signed [XW:0]     dx    = {1'b0, xc - xmin_i};
    wire signed [XW:0]     span  = {1'b0, xmax_i - xmin_i};
    wire signed [XW+12:0]  prod  = dy * dx;
    wire signed [XW+12:0]  quot  = (span == 0) ? $signed({(XW+13){1'b0}}) : prod / span;
    reg  signed [11:0]     tgt;
    // below the lower point: hold the lower setting or force zero
    always @* begin
        if (x_i < xmin_i) begin
            tgt = below_zero_i ? 12'h000 : {ymin_i[10], ymin_i};
        end else if (span == 0) begin
            tgt = {ymax_i[10], ymax_i};
        end else begin
            tgt = {ymin_i[10], ymin_i} + quot[11:0];
        end
    end
    // ----------------------------------------------------------------
    // smoothing, value held at sixteen times scale for resolution
    // ----------------------------------------------------------------
    reg  signed [16:0]     acc_q;
    wire signed [16:0]     diff  = {tgt[11], tgt, 4'h0} - acc_q;
    wire signed [11:0]     div   = {2'h0, filt_i} + 12'h001;
    wire signed [16:0]     step  = diff / div;
    // longer time gives smaller steps: steadier but slower
    always @(posedge mclk_i) begin
        if (rst_i) begin
            acc_q <= 17'h00000;
            y_o   <= 11'h000;
        end else begin
            if (filt_i == 10'h000) begin
                acc_q <= {tgt[11], tgt, 4'h0};
            end else if (tick_i) begin
                acc_q <= acc_q + step;
            end
            y_o <= acc_q[14:4];
        end
    end
endmodule // tic_curve

// file: rtl/tic_top.v
// terminal conditioning, run command decoding and input scaling
// --------------------------------------------------------------------
// Overview of operation
// - two-wire mode 2: input one enables, input two picks reverse
// - mode 2: input three enables, input one forward, two reverse
// - three-wire 1 buttons act on closing edge; last action wins
// - three-wire 1: stop contact held closed; opening it stops at once
// - mode 3: input three enables, input one runs, two level sets direction
// - three-wire 2: run on closing edge while enabled; open enable stops
// - up/down inputs ramp set frequency at configured rate per second
// - pulse frequency on input five mapped linearly to -100..100 percent
// - pulse measurement filtered, 0.00 to 10.00 s, default 0.01 s
// - only inputs one to three have a 0 to 3600 s change delay
// - low polarity word: one digit per input one to five, 1 inverts
// - positive logic active when connected; inverse active when open
// - high polarity word covers inputs six and seven likewise
// - analog curve maps voltage linearly between two points
// - input above maximum point computed as the maximum
// - input below minimum gives minimum setting or zero per selection
// - current input: one milliamp counts as half a volt
// - each analog input has its own filter time, default 0.10 s
// - curves two and three behave like curve one
// - below-minimum selection holds one digit per analog input
// - each analog input selects its curve through its own digit
// - digital inputs filtered 0.000 to 1.000 s, default 0.010 s
// --------------------------------------------------------------------
`timescale 1ns/1ns
`include "tic_consts.vh"
module tic_top #(
    parameter MS_CYCLES = `TIC_MS_TIME_NS / `TIC_CLK_PERIOD_NS,
    parameter FREQ_MAX  = 16'hC350
) (
    input  wire                mclk_i,
    input  wire                rst_i,
    input  wire [6:0]          term_raw_i,
    input  wire [4:0]          polarity_select_low_i,
    input  wire [1:0]          polarity_select_high_i,
    input  wire [9:0]          din_filter_time_i,
    input  wire [47:0]         input_delay_i,
    input  wire [1:0]          terminal_command_mode_i,
    input  wire                up_i,
    input  wire                down_i,
    input  wire [15:0]         updown_rate_i,
    input  wire [15:0]         pulse_min_hz_i,
    input  wire [15:0]         pulse_max_hz_i,
    input  wire [10:0]         pulse_min_set_i,
    input  wire [10:0]         pulse_max_set_i,
    input  wire [9:0]          pulse_filter_time_i,
    input  wire [44:0]         analog_in_i,
    input  wire [2:0]          analog_current_i,
    input  wire [8:0]          curve_select_i,
    input  wire [2:0]          below_minimum_select_i,
    input  wire [41:0]         curve_min_mv_i,
    input  wire [41:0]         curve_max_mv_i,
    input  wire [32:0]         curve_min_set_i,
    input  wire [32:0]         curve_max_set_i,
    input  wire [29:0]         analog_filter_time_i,
    output wire [6:0]          terminal_active_o,
    output reg                 forward_run_o,
    output reg                 reverse_run_o,
    output reg  [15:0]         set_freq_o,
    output reg  [15:0]         pulse_hz_o,
    output wire [10:0]         pulse_set_o,
    output wire [32:0]         analog_set_o
);
    // ----------------------------------------------------------------
    // time base: 1 ms, 10 ms and 100 ms ticks
    // ----------------------------------------------------------------
    reg  [19:0] ms_cnt_q;
    reg  [3:0]  t10_cnt_q;
    reg  [3:0]  t100_cnt_q;
    wire        tick_ms  = (ms_cnt_q == MS_CYCLES - 1);
    wire        tick_10  = tick_ms && (t10_cnt_q == `TIC_TICK10_MS - 1);
    wire        tick_100 = tick_10 && (t100_cnt_q == `TIC_TICK100_PER10 - 1);
    always @(posedge mclk_i) begin
        if (rst_i) begin
            ms_cnt_q   <= 20'h00000;
            t10_cnt_q  <= 4'h0;
            t100_cnt_q <= 4'h0;
        end else begin
            ms_cnt_q <= tick_ms ? 20'h00000 : ms_cnt_q + 20'h00001;
            if (tick_ms) begin
                t10_cnt_q <= tick_10 ? 4'h0 : t10_cnt_q + 4'h1;
            end
            if (tick_10) begin
                t100_cnt_q <= tick_100 ? 4'h0 : t100_cnt_q + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // polarity, filter and delay of the digital inputs
    // ----------------------------------------------------------------
    // raw bit high means the terminal is connected to common
    wire [6:0] pol = {polarity_select_high_i, polarity_select_low_i};
    wire [6:0] act = term_raw_i ^ pol;
    reg  [6:0] filt_q;
    reg  [9:0] fcnt_q [0:6];
    reg  [2:0] dly_q;
    reg  [15:0] dcnt_q [0:2];
    integer    i;
    // a change must persist for the whole filter time to be taken
    always @(posedge mclk_i) begin
        if (rst_i) begin
            filt_q <= 7'h00;
            for (i = 0; i < 7; i = i + 1) begin
                fcnt_q[i] <= 10'h000;
            end
        end else begin
            for (i = 0; i < 7; i = i + 1) begin
                if (act[i] == filt_q[i]) begin
                    fcnt_q[i] <= 10'h000;
                end else if (din_filter_time_i == 10'h000) begin
                    filt_q[i] <= act[i];
                end else if (tick_ms) begin
                    if (fcnt_q[i] + 10'h001 >= din_filter_time_i) begin
                        filt_q[i] <= act[i];
                        fcnt_q[i] <= 10'h000;
                    end else begin
                        fcnt_q[i] <= fcnt_q[i] + 10'h001;
                    end
                end
            end
        end
    end
    // change delay in 0.1 s steps, inputs one to three only
    always @(posedge mclk_i) begin
        if (rst_i) begin
            dly_q <= 3'h0;
            for (i = 0; i < 3; i = i + 1) begin
                dcnt_q[i] <= 16'h0000;
            end
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                if (filt_q[i] == dly_q[i]) begin
                    dcnt_q[i] <= 16'h0000;
                end else if (input_delay_i[i*16 +: 16] == 16'h0000) begin
                    dly_q[i] <= filt_q[i];
                end else if (tick_100) begin
                    if (dcnt_q[i] + 16'h0001 >= input_delay_i[i*16 +: 16]) begin
                        dly_q[i]  <= filt_q[i];
                        dcnt_q[i] <= 16'h0000;
                    end else begin
                        dcnt_q[i] <= dcnt_q[i] + 16'h0001;
                    end
                end
            end
        end
    end
    wire [6:0] cond = {filt_q[6:3], dly_q};
    assign terminal_active_o = cond;

    // ----------------------------------------------------------------
    // run command decoding
    // ----------------------------------------------------------------
    reg  [2:0] prev_q;
    reg        run_q;
    reg        rev_q;
    wire       rise1 = cond[0] & ~prev_q[0];
    wire       rise2 = cond[1] & ~prev_q[1];
    wire       three = terminal_command_mode_i[1];
    // three-wire latch; with both buttons in one cycle forward wins
    always @(posedge mclk_i) begin
        if (rst_i) begin
            prev_q <= 3'h0;
            run_q  <= 1'b0;
            rev_q  <= 1'b0;
        end else begin
            prev_q <= cond[2:0];
            if (!three || !cond[2]) begin
                run_q <= 1'b0;
            end else if (rise1) begin
                run_q <= 1'b1;
                rev_q <= 1'b0;
            end else if (rise2 && terminal_command_mode_i == `TIC_MODE_THREE_1) begin
                run_q <= 1'b1;
                rev_q <= 1'b1;
            end
        end
    end
    reg fwd_d;
    reg rev_d;
    always @* begin
        case (terminal_command_mode_i)
            `TIC_MODE_TWO_1: begin
                fwd_d = cond[0] & ~cond[1];
                rev_d = cond[1] & ~cond[0];
            end
            `TIC_MODE_TWO_2: begin
                fwd_d = cond[0] & ~cond[1];
                rev_d = cond[0] & cond[1];
            end
            `TIC_MODE_THREE_1: begin
                fwd_d = cond[2] & run_q & ~rev_q;
                rev_d = cond[2] & run_q & rev_q;
            end
            `TIC_MODE_THREE_2: begin
                fwd_d = cond[2] & run_q & ~cond[1];
                rev_d = cond[2] & run_q & cond[1];
            end
            default: begin
                fwd_d = 1'b0;
                rev_d = 1'b0;
            end
        endcase
    end
    always @(posedge mclk_i) begin
        if (rst_i) begin
            forward_run_o <= 1'b0;
            reverse_run_o <= 1'b0;
        end else begin
            forward_run_o <= fwd_d;
            reverse_run_o <= rev_d;
        end
    end

    // ----------------------------------------------------------------
    // up/down set frequency ramp
    // ----------------------------------------------------------------
    // rate in 0.001 Hz/s adds micro-hertz each ms; carries in 0.01 Hz
    reg  [13:0] frac_q;
    wire [16:0] sum   = {3'h0, frac_q} + {1'b0, updown_rate_i};
    wire [16:0] carry = sum / `TIC_UHZ_PER_CHZ;
    wire [16:0] rem   = sum % `TIC_UHZ_PER_CHZ;
    wire [17:0] upv   = {2'h0, set_freq_o} + {1'b0, carry};
    always @(posedge mclk_i) begin
        if (rst_i) begin
            frac_q     <= 14'h0000;
            set_freq_o <= 16'h0000;
        end else if (tick_ms && (up_i ^ down_i)) begin
            frac_q <= rem[13:0];
            if (up_i) begin
                set_freq_o <= (upv > {2'h0, FREQ_MAX}) ? FREQ_MAX : upv[15:0];
            end else begin
                set_freq_o <= ({1'b0, set_freq_o} < carry) ? 16'h0000 :
                              set_freq_o - carry[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // pulse frequency on input five: edges over a 100 ms gate
    // ----------------------------------------------------------------
    // taken after polarity only; the debounce filter would eat pulses
    reg         p_prev_q;
    reg  [12:0] p_cnt_q;
    // full count times ten needs 17 bits; all 17 kept so the cap sees the whole value
    wire [31:0] p_hz_w = p_cnt_q * `TIC_HZ_PER_COUNT;
    wire [16:0] p_hz   = p_hz_w[16:0];
    always @(posedge mclk_i) begin
        if (rst_i) begin
            p_prev_q   <= 1'b0;
            p_cnt_q    <= 13'h0000;
            pulse_hz_o <= 16'h0000;
        end else begin
            p_prev_q <= act[4];
            if (tick_100) begin
                p_cnt_q    <= 13'h0000;
                pulse_hz_o <= (p_hz > `TIC_PULSE_MAX_HZ) ? `TIC_PULSE_MAX_HZ : p_hz[15:0];
            end else if (act[4] && !p_prev_q && p_cnt_q != 13'h1FFF) begin
                p_cnt_q <= p_cnt_q + 13'h0001;
            end
        end
    end
    tic_curve #(.XW(16)) u_pulse (
        .mclk_i       (mclk_i),
        .rst_i        (rst_i),
        .tick_i       (tick_10),
        .x_i          (pulse_hz_o),
        .xmin_i       (pulse_min_hz_i),
        .xmax_i       (pulse_max_hz_i),
        .ymin_i       (pulse_min_set_i),
        .ymax_i       (pulse_max_set_i),
        .below_zero_i (1'b0),
        .filt_i       (pulse_filter_time_i),
        .y_o          (pulse_set_o)
    );

    // ----------------------------------------------------------------
    // analog inputs: unit conversion, curve choice, scaling
    // ----------------------------------------------------------------
    // codes 2 and 3 pick curves two and three; anything else curve one
    function [1:0] curve_idx;
        input [2:0] code;
        begin
            if (code == `TIC_CURVE_SEL_2) begin
                curve_idx = 2'h1;
            end else if (code == `TIC_CURVE_SEL_3) begin
                curve_idx = 2'h2;
            end else begin
                curve_idx = 2'h0;
            end
        end
    endfunction
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_ai
            wire [14:0] raw = analog_in_i[g*15 +: 15];
            wire [14:0] mv  = analog_current_i[g] ? {1'b0, raw[14:1]} : raw;
            wire [13:0] x   = (mv > {1'b0, `TIC_AI_MAX_MV}) ? `TIC_AI_MAX_MV : mv[13:0];
            wire [1:0]  c   = curve_idx(curve_select_i[g*3 +: 3]);
            tic_curve #(.XW(14)) u_ai (
                .mclk_i       (mclk_i),
                .rst_i        (rst_i),
                .tick_i       (tick_10),
                .x_i          (x),
                .xmin_i       (curve_min_mv_i[c*14 +: 14]),
                .xmax_i       (curve_max_mv_i[c*14 +: 14]),
                .ymin_i       (curve_min_set_i[c*11 +: 11]),
                .ymax_i       (curve_max_set_i[c*11 +: 11]),
                .below_zero_i (below_minimum_select_i[g]),
                .filt_i       (analog_filter_time_i[g*10 +: 10]),
                .y_o          (analog_set_o[g*11 +: 11])
            );
        end
    endgenerate
endmodule // tic_top

// file: bench/tic_field.sv
// field wiring model: switch contacts and a pulse source
`timescale 1ns/1ns
module tic_field (
    input  wire logic       mclk_i,
    input  wire logic [6:0] contact_i,
    input  wire logic [7:0] half_i,
    output logic      [6:0] term_raw_o
);
    logic [7:0] cnt_q;
    logic       pls_q = 1'b0;
    // ----------------------------------------------------------------
    // pulse source, toggles every half_i cycles; zero stops it
    // ----------------------------------------------------------------
    always @(negedge mclk_i) begin
        cnt_q <= (cnt_q + 8'h01 >= half_i) ? 8'h00 : cnt_q + 8'h01;
        if (half_i != 8'h00 && cnt_q + 8'h01 >= half_i)
            pls_q <= ~pls_q;
    end
    initial cnt_q = 8'h00;
    // pulses only ever reach input five; contacts are hard-wired levels
    assign term_raw_o = (half_i == 8'h00) ? contact_i :
                        {contact_i[6:5], pls_q, contact_i[3:0]};
endmodule // tic_field

// file: bench/tic_top_chk.sv
// concurrent checks on the ports of the terminal conditioning block
`timescale 1ns/1ns
module tic_top_chk (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [1:0]  terminal_command_mode_i,
    input  wire logic        up_i,
    input  wire logic        down_i,
    input  wire logic [6:0]  terminal_active_o,
    input  wire logic        forward_run_o,
    input  wire logic        reverse_run_o,
    input  wire logic [15:0] set_freq_o,
    input  wire logic [15:0] pulse_hz_o,
    input  wire logic [32:0] analog_set_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // short aliases for mode and conditioned terminal states
    wire [1:0] md = terminal_command_mode_i;
    wire [6:0] ta = terminal_active_o;
    // ----------------------------------------------------------------
    // run command decoding
    // ----------------------------------------------------------------
    two_fwd_a: assert property (md == 2'h1 && ta[0] && !ta[1] |-> ##[1:2]
        forward_run_o && !reverse_run_o) else $error("two-wire forward missing");
    two_rev_a: assert property (md == 2'h1 && ta[0] && ta[1] |-> ##[1:2]
        reverse_run_o && !forward_run_o) else $error("two-wire reverse missing");
    enable_stop_a: assert property (md[1] && !ta[2] |-> ##[1:2]
        !forward_run_o && !reverse_run_o) else $error("open enable did not stop");
    button_fwd_a: assert property (md == 2'h2 && ta[2] && $rose(ta[0]) |-> ##[1:2]
        forward_run_o && !reverse_run_o) else $error("forward button ignored");
    button_rev_a: assert property (md == 2'h2 && ta[2] && $rose(ta[1]) && !$rose(ta[0])
        |-> ##[1:2] reverse_run_o && !forward_run_o) else $error("reverse button ignored");
    run_dir_a: assert property (md == 2'h3 && ta[2] && ta[1] && $rose(ta[0]) |-> ##[1:2]
        reverse_run_o && !forward_run_o) else $error("run button direction wrong");
    run_excl_a: assert property (!(forward_run_o && reverse_run_o))
        else $error("both directions at once");
    // ----------------------------------------------------------------
    // up/down ramp and reset
    // ----------------------------------------------------------------
    freq_hold_a: assert property ((!(up_i ^ down_i))[*2] |=> $stable(set_freq_o))
        else $error("set frequency moved without up or down");
    freq_up_a: assert property ((up_i && !down_i)[*2] |=> set_freq_o >= $past(set_freq_o))
        else $error("set frequency fell while up held");
    freq_down_a: assert property ((down_i && !up_i)[*2] |=> set_freq_o <= $past(set_freq_o))
        else $error("set frequency rose while down held");
    reset_clear_a: assert property (disable iff (1'b0) rst_i |=> !forward_run_o &&
        !reverse_run_o && pulse_hz_o == 16'h0000 && analog_set_o == 33'h0)
        else $error("reset left state behind");
    // main scenarios reached
    cover property (md == 2'h2 && forward_run_o);
    cover property (md == 2'h3 && reverse_run_o);
    cover property (up_i ##1 $changed(set_freq_o));
endmodule // tic_top_chk
bind tic_top tic_top_chk tic_top_chk_i (.mclk_i, .rst_i, .terminal_command_mode_i, .up_i,
    .down_i, .terminal_active_o, .forward_run_o, .reverse_run_o, .set_freq_o, .pulse_hz_o,
    .analog_set_o);

// file: bench/tb_tic_top.sv
// testbench for the terminal conditioning block
`timescale 1ns/1ns
module tb_tic_top;
    // ----------------------------------------------------------------
    // stimulus and observation
    // ----------------------------------------------------------------
    logic        mclk_i, rst_i, up_i, down_i, forward_run, reverse_run;
    logic [6:0]  contact, term_raw, act;
    logic [7:0]  half;
    logic [4:0]  pol_lo;
    logic [1:0]  pol_hi, mode;
    logic [9:0]  dfilt;
    logic [47:0] dly;
    logic [15:0] rate, fq, phz;
    logic [44:0] ain;
    logic [2:0]  cur, bms;
    logic [41:0] cmin, cmax;
    logic [32:0] csmin, csmax, aset;
    logic [29:0] aft;
    logic [10:0] pset;
    logic [8:0]  csel;
    logic [9:0]  pft;
    int          error_cnt, compares;

    tic_field tic_field_i (.mclk_i(mclk_i), .contact_i(contact), .half_i(half),
        .term_raw_o(term_raw));
    // short ms tick and low frequency ceiling keep the run brief
    tic_top #(.MS_CYCLES(20), .FREQ_MAX(16'h0064)) tic_top_i (.mclk_i(mclk_i),
        .rst_i(rst_i), .term_raw_i(term_raw), .polarity_select_low_i(pol_lo),
        .polarity_select_high_i(pol_hi), .din_filter_time_i(dfilt), .input_delay_i(dly),
        .terminal_command_mode_i(mode), .up_i(up_i), .down_i(down_i), .updown_rate_i(rate),
        .pulse_min_hz_i(16'h0000), .pulse_max_hz_i(16'h0FA0), .pulse_min_set_i(11'h000),
        .pulse_max_set_i(11'h3E8), .pulse_filter_time_i(pft), .analog_in_i(ain),
        .analog_current_i(cur), .curve_select_i(csel), .below_minimum_select_i(bms),
        .curve_min_mv_i(cmin), .curve_max_mv_i(cmax), .curve_min_set_i(csmin),
        .curve_max_set_i(csmax), .analog_filter_time_i(aft), .terminal_active_o(act),
        .forward_run_o(forward_run), .reverse_run_o(reverse_run), .set_freq_o(fq), .pulse_hz_o(phz),
        .pulse_set_o(pset), .analog_set_o(aset));

    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic finish_test;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // set the contacts, let the run outputs settle, then judge them
    task automatic put(input logic [6:0] c, input logic [1:0] exp);
        contact = c;
        cyc(6);
        chk({forward_run, reverse_run}, exp);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_modes;
        put(7'h01, 2'b10);
        put(7'h02, 2'b01);
        put(7'h03, 2'b00);
        mode = 2'h1;
        put(7'h01, 2'b10);
        put(7'h03, 2'b01);
        put(7'h02, 2'b00);
        put(7'h00, 2'b00);
        mode = 2'h2;
        put(7'h04, 2'b00);
        put(7'h05, 2'b10);
        put(7'h04, 2'b10);
        put(7'h06, 2'b01);
        put(7'h00, 2'b00);
        put(7'h01, 2'b00);
        put(7'h05, 2'b00);
        put(7'h00, 2'b00);
        mode = 2'h3;
        put(7'h06, 2'b00);
        put(7'h07, 2'b01);
        put(7'h05, 2'b10);
        put(7'h01, 2'b00);
        put(7'h05, 2'b00);
        put(7'h00, 2'b00);
        mode = 2'h0;
    endtask
    task automatic t_terms;
        pol_lo = 5'h15;
        pol_hi = 2'h2;
        cyc(6);
        chk(act, 7'h55);
        contact = 7'h7F;
        cyc(6);
        chk(act, 7'h2A);
        {pol_lo, pol_hi, contact} = 14'h0000;
        dfilt = 10'h00A;
        contact = 7'h02;
        cyc(100);
        contact = 7'h00;
        cyc(300);
        chk(act[1], 1'b0);
        contact = 7'h02;
        cyc(150);
        chk(act[1], 1'b0);
        cyc(100);
        chk(act[1], 1'b1);
        dfilt = 10'h000;
        dly[15:0] = 16'h0001;
        contact = 7'h0B;
        cyc(20);
        chk(act[3:0], 4'hA);
        cyc(2100);
        chk(act[3:0], 4'hB);
        dly = 48'h0;
        cyc(2);
        contact = 7'h00;
        cyc(6);
    endtask
    task automatic t_ramp;
        rate = 16'h2710;
        up_i = 1'b1;
        cyc(200);
        up_i = 1'b0;
        cyc(4);
        chk(fq >= 16'h0009 && fq <= 16'h000B, 1'b1);
        down_i = 1'b1;
        cyc(400);
        down_i = 1'b0;
        cyc(4);
        chk(fq, 16'h0000);
        rate = 16'hFFFF;
        up_i = 1'b1;
        cyc(600);
        up_i = 1'b0;
        cyc(4);
        chk(fq, 16'h0064);
    endtask
    task automatic t_pulse;
        int i;
        half = 8'h05;
        for (i = 0; i < 6000 && phz === 16'h0000; i++)
            cyc(1);
        if (phz === 16'h0000) begin
            error_cnt++;
            finish_test();
        end else begin
            cyc(2100);
            chk(phz == 16'h07C6 || phz == 16'h07D0, 1'b1);
            chk(pset >= 11'h1F1 && pset <= 11'h1F4, 1'b1);
            half = 8'h00;
        end
    endtask
    task automatic t_analog;
        cyc(500);
        chk(aset, {11'h190, 11'h60C, 11'h1F4});
        ain = {15'h1F40, 15'h03E8, 15'h2EE0};
        cur = 3'h4;
        bms = 3'h2;
        cyc(500);
        chk(aset, {11'h190, 11'h000, 11'h3E8});
        aft = {10'h00A, 20'h0};
        ain[44:30] = 15'h07D0;
        cyc(400);
        chk(aset[32:22] > 11'h000 && aset[32:22] < 11'h190, 1'b1);
    endtask
    task automatic t_reset;
        mode = 2'h2;
        put(7'h05, 2'b10);
        // button let go inside reset: a latch that survived would restart
        rst_i = 1'b1;
        contact = 7'h04;
        cyc(2);
        chk({forward_run, reverse_run, phz, pset}, 29'h0);
        chk(aset, 33'h0);
        rst_i = 1'b0;
        cyc(6);
        chk({forward_run, reverse_run}, 2'b00);
    endtask
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        {rst_i, up_i, down_i, contact, half, pol_lo, pol_hi, mode} = {3'h4, 24'h000000};
        {csel, pft} = {9'h0D1, 10'h000};
        {dfilt, dly, rate, cur, bms} = {10'h000, 48'h0, 16'h03E8, 6'h00};
        ain = {15'h0FA0, 15'h03E8, 15'h1388};
        cmin = {14'h07D0, 14'h07D0, 14'h0000};
        cmax = {14'h1770, 14'h1770, 14'h2710};
        csmin = {11'h000, 11'h60C, 11'h000};
        csmax = {11'h320, 11'h1F4, 11'h3E8};
        aft = 30'h0;
        error_cnt = 0;
        compares = 0;
        cyc(16);
        rst_i = 1'b0;
        t_modes();
        t_terms();
        t_ramp();
        t_pulse();
        t_analog();
        t_reset();
        finish_test();
    end
    initial begin
        #2000000;
        error_cnt++;
        finish_test();
    end
endmodule // tb_tic_top
